// file: bus_address_latch.sv
// captures the address switch and decodes talk-only mode
`timescale 1ns/10ps
`default_nettype none
module bus_address_latch (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reload,
    input wire logic [4:0] address_switch,
    output logic [4:0] bus_addr,
    output logic talk_only
);

    logic first_reg;
    logic [4:0] addr_reg;
    logic talk_only_reg;

    // -----------------------------------------------------------
    // switch capture after reset release and on device clear
    // -----------------------------------------------------------
    // first cycle after release, the strap is caught by a clocked load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // one setting gives both listen and talk address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= 5'h00;
            talk_only_reg <= 1'b0;
        end else if (first_reg || reload) begin
            addr_reg <= address_switch;
            talk_only_reg <= (address_switch == srq_status_pkg::TALK_ONLY_ADDR);
        end
    end

    assign bus_addr = addr_reg;
    assign talk_only = talk_only_reg;

endmodule
`default_nettype wire

// file: cond_flag_bank.sv
// bank of sticky condition flags, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module cond_flag_bank (
    input wire logic clk,
    input wire logic reset_n,
    flag_bus_if.owner fb
);

    // -----------------------------------------------------------
    // one sticky flag per status bit
    // -----------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < srq_status_pkg::STATUS_WIDTH; i = i + 1) begin : g_flag
            logic flag_reg;
            // a set arriving with a clear is kept, so no event is lost
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag_reg <= srq_status_pkg::COND_RESET[i];
                end else if (fb.set_vec[i]) begin
                    flag_reg <= 1'b1;
                end else if (fb.clear_vec[i]) begin
                    flag_reg <= 1'b0;
                end
            end
            assign fb.flags[i] = flag_reg;
        end
    endgenerate

endmodule
`default_nettype wire

// file: flag_bus_if.sv
// set, clear and state vectors of the sticky condition flags
`timescale 1ns/10ps
`default_nettype none
interface flag_bus_if;
    logic [7:0] set_vec;
    logic [7:0] clear_vec;
    logic [7:0] flags;

    modport owner (input set_vec, input clear_vec, output flags);
    modport user (output set_vec, output clear_vec, input flags);
endinterface
`default_nettype wire

// file: ieee488_controller_model.sv
// behavioural bus controller facing the status logic
`timescale 1ns/10ps
`default_nettype none
module ieee488_controller_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic [7:0] bus_byte,
    output logic bus_byte_valid,
    output logic atn,
    output logic ifc,
    output logic ren,
    output logic tx_ready
);
    // ------------------------------
    // bus tasks
    // ------------------------------
    initial begin
        bus_byte = 8'h00;
        bus_byte_valid = 1'b0;
        atn = 1'b0;
        ifc = 1'b0;
        ren = 1'b0;
        tx_ready = 1'b0;
    end
    // released data lines show the inverse so a stale byte never looks valid
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk);
        #1;
        atn = 1'b1;
        bus_byte = b;
        bus_byte_valid = 1'b1;
        @(posedge clk);
        #1;
        bus_byte_valid = 1'b0;
        bus_byte = ~b;
    endtask
    // unlisten first, then talker, then listener
    task automatic addr_seq(input logic [4:0] talker, input logic [4:0] listener);
        send_cmd(8'h3F);
        send_cmd(8'h40 | {3'h0, talker});
        send_cmd(8'h20 | {3'h0, listener});
    endtask
    task automatic pulse_ifc();
        @(posedge clk);
        #1;
        ifc = 1'b1;
        @(posedge clk);
        #1;
        ifc = 1'b0;
    endtask
    // one poll byte; leaves unknown if the talker never offers
    task automatic poll(output logic [7:0] got);
        int n;
        got = 8'hXX;
        send_cmd(8'h18);
        atn = 1'b0;
        n = 0;
        while (tx_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (tx_valid === 1'b1) got = tx_byte;
        tx_ready = 1'b1;
        @(posedge clk);
        #1;
        tx_ready = 1'b0;
        send_cmd(8'h19);
    endtask
endmodule
`default_nettype wire

// file: ieee488_status_srq_logic.sv
// status byte, service request and addressing of the bus interface
`timescale 1ns/10ps
`default_nettype none
module ieee488_status_srq_logic (
    input wire logic clk,
    input wire logic reset_n,
    // bus side, already through the acceptor handshake
    input wire logic [7:0] bus_byte,
    input wire logic bus_byte_valid,
    input wire logic atn,
    input wire logic ifc,
    input wire logic ren,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic srq_out,
    output logic srq_oe,
    // addressing and mode
    input wire logic [4:0] address_switch,
    input wire logic powerup_request_switch,
    output logic listen_active,
    output logic talk_active,
    output logic talk_only,
    output logic remote,
    output logic lockout,
    output logic reading_send,
    output logic device_clear,
    // mask programming from the program-code parser
    input wire logic mask_write_valid,
    input wire logic [7:0] mask_write_data,
    input wire logic status_clear,
    output logic [7:0] service_enable_mask,
    // condition sources
    input wire logic reading_available,
    input wire logic reading_byte_taken,
    input wire logic syntax_error,
    input wire logic self_test_fail,
    input wire logic converter_fail,
    input wire logic cal_checksum_fail,
    input wire logic panel_request_button,
    input wire logic cal_fail,
    output logic [7:0] condition_status_byte,
    output logic request_active
);

    flag_bus_if fb ();

    logic [7:0] cmd;
    logic cmd_valid;
    logic [4:0] bus_addr;
    logic talk_only_w;
    logic reload;
    logic [7:0] mask_reg;
    logic srq_reg;
    logic [7:0] status_reg;
    logic listen_reg;
    logic talk_reg;
    logic spoll_reg;
    logic remote_reg;
    logic lockout_reg;
    logic clear_reg;
    logic talk_only_reg;
    logic reading_send_reg;
    logic avail_d_reg;
    logic panel_d_reg;
    logic [7:0] tx_byte_reg;
    logic tx_valid_reg;
    logic srq_out_reg;
    logic request_next;
    logic [7:0] status_next;
    srq_status_pkg::tx_state_t tx_state_reg;
    srq_status_pkg::tx_state_t tx_state_next;

    // -----------------------------------------------------------
    // helpers
    // -----------------------------------------------------------
    // matches an addressed command of one group against our address
    function automatic logic addr_match(input logic [7:0] b, input logic [7:0] group, input logic [4:0] a);
        addr_match = ((b & srq_status_pkg::GROUP_MASK) == group)
                     && ((b & srq_status_pkg::ADDR_FIELD) == {3'h0, a});
    endfunction

    assign cmd = bus_byte & srq_status_pkg::PARITY_STRIP;
    assign cmd_valid = bus_byte_valid && atn;

    // -----------------------------------------------------------
    // submodules
    // -----------------------------------------------------------
    cond_flag_bank u_flags (
        .clk(clk),
        .reset_n(reset_n),
        .fb(fb)
    );

    // device clear rereads the switch, as at power-up
    assign reload = clear_reg;

    bus_address_latch u_addr (
        .clk(clk),
        .reset_n(reset_n),
        .reload(reload),
        .address_switch(address_switch),
        .bus_addr(bus_addr),
        .talk_only(talk_only_w)
    );

    // -----------------------------------------------------------
    // condition sources
    // -----------------------------------------------------------
    // edge history for the reading and the panel button
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avail_d_reg <= 1'b0;
            panel_d_reg <= 1'b0;
        end else begin
            avail_d_reg <= reading_available;
            panel_d_reg <= panel_request_button;
        end
    end

    // set vector: edge pulses for data ready and the panel button, levels for the error sources
    always_comb begin
        fb.set_vec = srq_status_pkg::BYTE_ZERO;
        fb.set_vec[srq_status_pkg::BIT_DATA_READY] = reading_available && !avail_d_reg;
        fb.set_vec[srq_status_pkg::BIT_SYNTAX] = syntax_error;
        fb.set_vec[srq_status_pkg::BIT_INTERNAL] = self_test_fail || converter_fail || cal_checksum_fail;
        // panel button is dead only in remote with lockout
        fb.set_vec[srq_status_pkg::BIT_PANEL] = panel_request_button && !panel_d_reg
                                                && !(remote_reg && lockout_reg);
        fb.set_vec[srq_status_pkg::BIT_CAL_FAIL] = cal_fail;
    end

    // clear vector: status clear drops the latched errors; data ready has its own clear
    always_comb begin
        fb.clear_vec = status_clear ? srq_status_pkg::BYTE_ZERO | ~srq_status_pkg::BYTE_ZERO
                                    : srq_status_pkg::BYTE_ZERO;
        fb.clear_vec[srq_status_pkg::BIT_DATA_READY] = reading_byte_taken || !reading_available;
        fb.clear_vec[srq_status_pkg::BIT_ALWAYS_ZERO] = 1'b1;
        fb.clear_vec[srq_status_pkg::BIT_REQUEST] = 1'b1;
    end

    // -----------------------------------------------------------
    // mask register
    // -----------------------------------------------------------
    // only the six low bits are stored; device clear zeroes them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= srq_status_pkg::MASK_RESET;
        end else if (clear_reg) begin
            mask_reg <= srq_status_pkg::MASK_RESET;
        end else if (mask_write_valid) begin
            mask_reg <= mask_write_data & srq_status_pkg::MASK_PROG_BITS;
        end
    end

    // -----------------------------------------------------------
    // service request and reported byte
    // -----------------------------------------------------------
    // request from enabled true conditions; bit 7 gated by the rear switch
    always_comb begin
        request_next = |(fb.flags & mask_reg & srq_status_pkg::MASK_PROG_BITS)
                       || (fb.flags[srq_status_pkg::BIT_POWERUP] && powerup_request_switch);
        status_next = fb.flags;
        status_next[srq_status_pkg::BIT_ALWAYS_ZERO] = 1'b0;
        status_next[srq_status_pkg::BIT_REQUEST] = request_next;
    end

    // request drops as soon as nothing enabled is true
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srq_reg <= 1'b0;
            status_reg <= srq_status_pkg::BYTE_ZERO;
        end else begin
            srq_reg <= request_next;
            status_reg <= status_next;
        end
    end

    // open-drain line: enable pulls low while requesting, ignores other traffic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srq_out_reg <= 1'b0;
        end else begin
            srq_out_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------
    // addressing and interface state
    // -----------------------------------------------------------
    // listen and talk follow our one address; unaddressed by the other role
    // parallel poll commands fall through untouched: no poll response exists
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            listen_reg <= 1'b0;
            talk_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else if (ifc || talk_only_w) begin
            listen_reg <= 1'b0;
            talk_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else if (cmd_valid) begin
            if (cmd == srq_status_pkg::CMD_UNL) begin
                listen_reg <= 1'b0;
            end else if (cmd == srq_status_pkg::CMD_UNT) begin
                talk_reg <= 1'b0;
            end else if (addr_match(cmd, srq_status_pkg::GROUP_LISTEN, bus_addr)) begin
                listen_reg <= 1'b1;
                talk_reg <= 1'b0;
            end else if (addr_match(cmd, srq_status_pkg::GROUP_TALK, bus_addr)) begin
                talk_reg <= 1'b1;
                listen_reg <= 1'b0;
            end else if ((cmd & srq_status_pkg::GROUP_MASK) == srq_status_pkg::GROUP_TALK) begin
                talk_reg <= 1'b0;
            end else if (cmd == srq_status_pkg::CMD_SPE) begin
                spoll_reg <= 1'b1;
            end else if (cmd == srq_status_pkg::CMD_SPD) begin
                spoll_reg <= 1'b0;
            end
        end
    end

    // remote survives interface clear; only the enable line, go-to-local or talk-only mode ends it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
        end else if (!ren || talk_only_w) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
        end else if (cmd_valid) begin
            if (addr_match(cmd, srq_status_pkg::GROUP_LISTEN, bus_addr)) begin
                remote_reg <= 1'b1;
            end else if (cmd == srq_status_pkg::CMD_GTL && listen_reg) begin
                remote_reg <= 1'b0;
            end else if (cmd == srq_status_pkg::CMD_LLO) begin
                lockout_reg <= 1'b1;
            end
        end
    end

    // device clear pulse: universal, or selective while listening
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= cmd_valid && !talk_only_w
                         && ((cmd == srq_status_pkg::CMD_DCL)
                             || (cmd == srq_status_pkg::CMD_SDC && listen_reg));
        end
    end

    // readings go out when talked outside a poll, or always in talk-only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reading_send_reg <= 1'b0;
            talk_only_reg <= 1'b0;
        end else begin
            reading_send_reg <= talk_only_w || (talk_reg && !spoll_reg && !atn && !ifc);
            talk_only_reg <= talk_only_w;
        end
    end

    // -----------------------------------------------------------
    // serial poll talker
    // -----------------------------------------------------------
    // one status byte per poll cycle; controller reasserts attention to end it
    always_comb begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            srq_status_pkg::TX_IDLE: begin
                if (talk_reg && spoll_reg && !atn) begin
                    tx_state_next = srq_status_pkg::TX_OFFER;
                end
            end
            srq_status_pkg::TX_OFFER: begin
                if (atn || !talk_reg || !spoll_reg) begin
                    tx_state_next = srq_status_pkg::TX_IDLE;
                end else if (tx_ready) begin
                    tx_state_next = srq_status_pkg::TX_DONE;
                end
            end
            srq_status_pkg::TX_DONE: begin
                if (atn || !talk_reg || !spoll_reg) begin
                    tx_state_next = srq_status_pkg::TX_IDLE;
                end
            end
            default: begin
                tx_state_next = srq_status_pkg::TX_IDLE;
            end
        endcase
    end

    // interface clear aborts a byte in flight
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= srq_status_pkg::TX_IDLE;
        end else if (ifc) begin
            tx_state_reg <= srq_status_pkg::TX_IDLE;
        end else begin
            tx_state_reg <= tx_state_next;
        end
    end

    // byte is frozen while offered so the handshake sees stable data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_byte_reg <= srq_status_pkg::BYTE_ZERO;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_valid_reg <= (tx_state_next == srq_status_pkg::TX_OFFER) && !ifc;
            if (tx_state_reg == srq_status_pkg::TX_IDLE) begin
                tx_byte_reg <= status_reg;
            end
        end
    end

    // -----------------------------------------------------------
    // outputs
    // -----------------------------------------------------------
    assign tx_byte = tx_byte_reg;
    assign tx_valid = tx_valid_reg;
    assign srq_out = srq_out_reg;
    assign srq_oe = srq_reg;
    assign listen_active = listen_reg;
    assign talk_active = talk_reg;
    assign talk_only = talk_only_reg;
    assign remote = remote_reg;
    assign lockout = lockout_reg;
    assign reading_send = reading_send_reg;
    assign device_clear = clear_reg;
    assign service_enable_mask = mask_reg;
    assign condition_status_byte = status_reg;
    assign request_active = srq_reg;

endmodule
`default_nettype wire

// file: srq_status_pkg.sv
// constants shared by the status and service-request logic
package srq_status_pkg;

    // condition bit positions in the status byte
    localparam int BIT_DATA_READY = 0;
    localparam int BIT_ALWAYS_ZERO = 1;
    localparam int BIT_SYNTAX = 2;
    localparam int BIT_INTERNAL = 3;
    localparam int BIT_PANEL = 4;
    localparam int BIT_CAL_FAIL = 5;
    localparam int BIT_REQUEST = 6;
    localparam int BIT_POWERUP = 7;
    localparam int STATUS_WIDTH = 8;
    localparam int ADDR_WIDTH = 5;

    // reset values and the programmable mask bits
    localparam logic [7:0] COND_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] MASK_PROG_BITS = 8'h3F;

    // bus command bytes, parity bit stripped
    localparam logic [7:0] PARITY_STRIP = 8'h7F;
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_LLO = 8'h11;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;
    localparam logic [7:0] CMD_UNL = 8'h3F;
    localparam logic [7:0] CMD_UNT = 8'h5F;
    localparam logic [7:0] GROUP_MASK = 8'h60;
    localparam logic [7:0] GROUP_LISTEN = 8'h20;
    localparam logic [7:0] GROUP_TALK = 8'h40;
    localparam logic [7:0] ADDR_FIELD = 8'h1F;
    localparam logic [4:0] TALK_ONLY_ADDR = 5'h1F;

    // talker sequencing for the serial poll byte
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_OFFER = 2'b01,
        TX_DONE = 2'b10
    } tx_state_t;

endpackage

// file: status_srq_checker_asserts.sv
// concurrent checks on the status byte and service request outputs
`timescale 1ns/10ps
`default_nettype none
module status_srq_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic srq_out,
    input wire logic srq_oe,
    input wire logic request_active,
    input wire logic [7:0] condition_status_byte,
    input wire logic [7:0] service_enable_mask,
    input wire logic [7:0] mask_write_data,
    input wire logic mask_write_valid,
    input wire logic device_clear,
    input wire logic bus_byte_valid,
    input wire logic reading_available,
    input wire logic syntax_error,
    input wire logic self_test_fail,
    input wire logic converter_fail,
    input wire logic cal_checksum_fail,
    input wire logic cal_fail
);
    // ------------------------------
    // sequences and properties
    // ------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a reading gone for two edges can not have re-set the ready flag
    sequence reading_gone;
        !reading_available ##1 !reading_available;
    endsequence
    // a device clear in flight would zero the mask under the write
    sequence clean_mask_write;
        mask_write_valid && !device_clear && !bus_byte_valid;
    endsequence
    property flag_sets(logic cause, int pos);
        cause |-> ##2 condition_status_byte[pos];
    endproperty
    AST_BIT1_ZERO: assert property (condition_status_byte[1] == 1'b0) else $error("bit 1 set");
    AST_SRQ_OPEN_DRAIN: assert property (srq_out == 1'b0) else $error("srq data not low");
    AST_REQ_PAIR: assert property (request_active == srq_oe) else $error("request flags differ");
    AST_BIT6_REQ: assert property (condition_status_byte[6] == srq_oe) else $error("bit 6 off request");
    AST_SYNTAX_SET: assert property (flag_sets(syntax_error, 2)) else $error("syntax flag missing");
    AST_INTERNAL_SET: assert property (flag_sets(self_test_fail || converter_fail || cal_checksum_fail, 3))
        else $error("internal flag missing");
    AST_CAL_SET: assert property (flag_sets(cal_fail, 5)) else $error("calibration flag missing");
    AST_MASK_TOP: assert property (service_enable_mask[7:6] == 2'b00) else $error("mask top bits set");
    AST_MASK_WRITE: assert property (clean_mask_write |=>
        service_enable_mask == ($past(mask_write_data) & srq_status_pkg::MASK_PROG_BITS))
        else $error("mask write lost");
    AST_READY_CLEAR: assert property (reading_gone |-> ##1 !condition_status_byte[0])
        else $error("ready flag stuck");
endmodule
bind ieee488_status_srq_logic status_srq_checker u_status_srq_checker (.clk, .reset_n, .srq_out, .srq_oe,
    .request_active, .condition_status_byte, .service_enable_mask, .mask_write_data, .mask_write_valid,
    .device_clear, .bus_byte_valid, .reading_available, .syntax_error, .self_test_fail, .converter_fail,
    .cal_checksum_fail, .cal_fail);
`default_nettype wire

// file: tb_ieee488_status_srq_logic.sv
// self-checking bench for the status and service-request logic
`timescale 1ns/10ps
`default_nettype none
module tb_ieee488_status_srq_logic;
    // ------------------------------
    // signals and model state
    // ------------------------------
    logic clk = 1'b0, reset_n = 1'b0, powerup_request_switch = 1'b1, mask_write_valid = 1'b0;
    logic status_clear = 1'b0, reading_available = 1'b0, reading_byte_taken = 1'b0, syntax_error = 1'b0;
    logic self_test_fail = 1'b0, converter_fail = 1'b0, cal_checksum_fail = 1'b0, cal_fail = 1'b0;
    logic panel_request_button = 1'b0;
    logic [4:0] address_switch = 5'h0B;
    logic [7:0] mask_write_data = 8'h00, tx_byte, service_enable_mask, condition_status_byte, got;
    wire logic [7:0] bus_byte;
    wire logic bus_byte_valid, atn, ifc, ren, tx_ready;
    logic tx_valid, srq_out, srq_oe, listen_active, talk_active, talk_only, remote, lockout, reading_send;
    logic device_clear, request_active;
    logic [31:0] seed = 32'd78397, r;
    logic [7:0] flags, mask;
    int n_fail = 0, tests_run = 0;
    always #20 clk = ~clk;
    ieee488_status_srq_logic DUT (.clk, .reset_n, .bus_byte, .bus_byte_valid, .atn, .ifc, .ren, .tx_ready,
        .tx_byte, .tx_valid, .srq_out, .srq_oe, .address_switch, .powerup_request_switch, .listen_active,
        .talk_active, .talk_only, .remote, .lockout, .reading_send, .device_clear, .mask_write_valid,
        .mask_write_data, .status_clear, .service_enable_mask, .reading_available, .reading_byte_taken,
        .syntax_error, .self_test_fail, .converter_fail, .cal_checksum_fail, .panel_request_button, .cal_fail,
        .condition_status_byte, .request_active);
    ieee488_controller_model ctl (.clk, .tx_valid, .tx_byte, .bus_byte, .bus_byte_valid, .atn, .ifc, .ren,
        .tx_ready);
    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // request only from enabled flags; bit 7 gated by the rear switch
    function automatic logic exp_req();
        return (|(flags[5:0] & mask[5:0])) | (flags[7] & powerup_request_switch);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e, input string msg);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, g, e);
        end
    endtask
    task automatic compare_all();
        check(condition_status_byte, (flags & 8'hBD) | {1'b0, exp_req(), 6'h00}, "status byte");
        check({6'h00, srq_oe, srq_out}, {6'h00, exp_req(), 1'b0}, "request line");
        check(service_enable_mask, mask, "mask");
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        tick(3);
        reset_n = 1'b1;
        flags = 8'h80;
        mask = 8'h00;
        tick(3);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        #(40 * 20000);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        do_reset();
        compare_all();
        status_clear = 1'b1;
        tick(1);
        status_clear = 1'b0;
        flags &= 8'h03;
        tick(3);
        compare_all();
        // random condition pulses, mask writes and clears against the model
        repeat (24) begin
            r = xs();
            powerup_request_switch = r[8];
            mask_write_data = r[31:24];
            mask_write_valid = r[9];
            if (r[9]) mask = r[31:24] & 8'h3F;
            {cal_fail, cal_checksum_fail, converter_fail, self_test_fail, syntax_error} = r[4:0];
            if (r[0]) flags |= 8'h04;
            if (|r[3:1]) flags |= 8'h08;
            if (r[4]) flags |= 8'h20;
            if (r[5] && !panel_request_button) flags |= 8'h10;
            if (r[6] && !reading_available) flags |= 8'h01;
            if (!r[6]) flags &= 8'hFE;
            panel_request_button = r[5];
            reading_available = r[6];
            tick(1);
            {mask_write_valid, cal_fail, cal_checksum_fail, converter_fail, self_test_fail, syntax_error} = 6'h00;
            tick(2);
            if (r[10]) begin
                reading_byte_taken = 1'b1;
                tick(1);
                reading_byte_taken = 1'b0;
                flags &= 8'hFE;
            end
            if (r[11]) begin
                status_clear = 1'b1;
                tick(1);
                status_clear = 1'b0;
                flags &= 8'h03;
            end
            tick(4);
            compare_all();
        end
        ctl.ren = 1'b1;
        ctl.addr_seq(5'h1E, 5'h0B);
        tick(2);
        check({5'h00, listen_active, talk_active, remote}, 8'h05, "addressed to listen");
        check({7'h00, talk_only}, 8'h00, "talk-only off");
        ctl.pulse_ifc();
        tick(2);
        check({6'h00, listen_active, remote}, 8'h01, "interface clear");
        ctl.addr_seq(5'h0B, 5'h1E);
        tick(2);
        check({7'h00, talk_active}, 8'h01, "addressed to talk");
        ctl.poll(got);
        check(got, (flags & 8'hBD) | {1'b0, exp_req(), 6'h00}, "poll byte");
        // lockout, then universal device clear: pulse stands one cycle, mask zeroed one later
        ctl.send_cmd(8'h11);
        ctl.send_cmd(8'h14);
        check({6'h00, lockout, device_clear}, 8'h03, "lockout and device clear");
        mask = 8'h00;
        tick(2);
        compare_all();
        address_switch = 5'h1F;
        do_reset();
        check({6'h00, talk_only, reading_send}, 8'h03, "talk-only mode");
        summarize();
    end
endmodule
`default_nettype wire
